// >>> rtl/flash_host_controller.sv
// Behaviour
// - Strobe returns high before each read
// - Erase is 20 then D0, same address (each cycle takes addr_q as it starts; an ADDR write in between moves the D0)
// - Never output and write enable both low
// - Only defined command codes are written
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_host_controller
    import flash_host_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [20:0] flash_addr,
    input wire logic [7:0] flash_dq_i,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic powerdown_reset_n,
    output logic high_voltage_level,
    input wire logic ready_busy_n
);

    // Registers
    logic [5:0] cmd_q;
    logic [20:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic refused_q;
    logic suspended_q;
    logic vhh_q;
    logic [31:0] prdata_q;
    read_mode_t mode_q;
    seq_state_t state_q;
    second_kind_t sec_q;
    logic [7:0] code2_q;
    logic [3:0] op_q;
    logic [`CNT_W-1:0] cnt_q;
    logic cyc_start_q;
    logic cyc_write_q;
    logic [7:0] cyc_wdata_q;
    logic cyc_done;
    logic [7:0] cyc_rdata;

    // Bus decode
    wire setup_ph = psel && !penable && clk_en;
    wire access_ph = psel && penable && clk_en;
    wire hit_cmd = (paddr == `CMD_OFS);
    wire hit_addr = (paddr == `ADDR_OFS);
    wire hit_wdata = (paddr == `WDATA_OFS);
    wire hit_status = (paddr == `STATUS_OFS);
    wire hit_any = hit_cmd || hit_addr || hit_wdata || hit_status;
    wire wr_cmd = access_ph && pwrite && hit_cmd;
    wire wr_addr = access_ph && pwrite && hit_addr;
    wire wr_wdata = access_ph && pwrite && hit_wdata;
    wire wr_status = access_ph && pwrite && hit_status;
    wire idle = (state_q == SEQ_IDLE);
    wire [3:0] new_op = pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
    wire new_alt = pwdata[`CMD_ALT_BIT];

    assign pready = clk_en;
    assign pslverr = psel && penable && !hit_any;
    assign prdata = prdata_q;

    // Operation decode
    logic dec_valid;
    logic dec_first;
    second_kind_t dec_second;
    logic [7:0] dec_code1;
    logic [7:0] dec_code2;

    always_comb
    begin
        dec_valid = 1'b1;
        dec_first = 1'b1;
        dec_second = SEC_NONE;
        dec_code1 = `FC_READ_ARRAY;
        dec_code2 = `FC_CONFIRM;
        unique case (new_op)
            `OP_READ_ARRAY: dec_code1 = `FC_READ_ARRAY;
            `OP_READ_ID:
            begin
                dec_code1 = `FC_READ_ID;
                dec_second = SEC_READ;
            end
            `OP_READ_STATUS:
            begin
                dec_code1 = `FC_READ_STATUS;
                dec_second = SEC_READ;
            end
            `OP_CLEAR_STATUS: dec_code1 = `FC_CLEAR_STATUS;
            `OP_ERASE:
            begin
                dec_code1 = `FC_ERASE_SETUP;
                dec_second = SEC_WRITE;
            end
            `OP_PROGRAM:
            begin
                dec_code1 = new_alt ? `FC_PROGRAM_ALT : `FC_PROGRAM;
                dec_code2 = wdata_q;
                dec_second = SEC_WRITE;
            end
            `OP_SUSPEND: dec_code1 = `FC_SUSPEND;
            `OP_RESUME: dec_code1 = `FC_CONFIRM;
            `OP_LOCK_BLOCK:
            begin
                dec_code1 = `FC_LOCK_SETUP;
                dec_code2 = `FC_LOCK_BLOCK;
                dec_second = SEC_WRITE;
            end
            `OP_LOCK_MASTER:
            begin
                dec_code1 = `FC_LOCK_SETUP;
                dec_code2 = `FC_LOCK_MASTER;
                dec_second = SEC_WRITE;
            end
            `OP_UNLOCK_ALL:
            begin
                dec_code1 = `FC_LOCK_SETUP;
                dec_second = SEC_WRITE;
            end
            `OP_READ:
            begin
                dec_first = 1'b0;
                dec_second = SEC_READ;
            end
            `OP_POWER_DOWN: dec_first = 1'b0;
            default: dec_valid = 1'b0;
        endcase
    end

    wire wsm_running = !ready_busy_n && !suspended_q;
    wire refuse_ra = (new_op == `OP_READ_ARRAY) && wsm_running;
    wire refuse_cs = (new_op == `OP_CLEAR_STATUS) && suspended_q;
    wire refuse = !idle || !dec_valid || refuse_ra || refuse_cs;
    wire go = wr_cmd && !refuse;

    // Register writes and readback
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_q <= `CMD_RST;
            addr_q <= `ADDR_RST;
            wdata_q <= `BYTE_RST;
            refused_q <= 1'b0;
            vhh_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (go)
            begin
                cmd_q <= pwdata[5:0];
                vhh_q <= pwdata[`CMD_VHH_BIT];
            end
            if (wr_addr)
                addr_q <= pwdata[20:0];
            if (wr_wdata)
                wdata_q <= pwdata[7:0];
            if (wr_cmd && refuse)
                refused_q <= 1'b1;
            else if (wr_status && pwdata[`ST_REFUSED_BIT])
                refused_q <= 1'b0;
        end
    end

    logic [31:0] status_word;
    always_comb
    begin
        status_word = '0;
        status_word[`ST_BUSY_BIT] = !idle;
        status_word[`ST_RYBY_BIT] = ready_busy_n;
        status_word[`ST_SUSP_BIT] = suspended_q;
        status_word[`ST_REFUSED_BIT] = refused_q;
        status_word[`ST_MODE_MSB:`ST_MODE_LSB] = mode_q;
        // completion flag of last status read
        status_word[`ST_SRDY_BIT] = (mode_q == MODE_STATUS) && rdata_q[`SR_READY_BIT];
        status_word[`ST_RDATA_MSB:`ST_RDATA_LSB] = rdata_q;
    end

    wire [31:0] read_mux = hit_cmd ? 32'(cmd_q) :
        hit_addr ? 32'(addr_q) :
        hit_wdata ? 32'(wdata_q) :
        hit_status ? status_word : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= '0;
        else if (setup_ph && !pwrite)
            prdata_q <= read_mux;
    end

    // Sequencer
    wire finish = ((state_q == SEQ_FIRST) && cyc_done && (sec_q == SEC_NONE)) ||
                  ((state_q == SEQ_SECOND) && cyc_done) ||
                  ((state_q == SEQ_PD_WAKE) && (cnt_q == '0));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= SEQ_IDLE;
            sec_q <= SEC_NONE;
            code2_q <= `BYTE_RST;
            op_q <= `OP_READ_ARRAY;
            cnt_q <= '0;
            cyc_start_q <= 1'b0;
            cyc_write_q <= 1'b0;
            cyc_wdata_q <= `BYTE_RST;
            rdata_q <= `BYTE_RST;
        end
        else if (clk_en)
        begin
            cyc_start_q <= 1'b0;
            unique case (state_q)
                SEQ_IDLE:
                begin
                    if (go)
                    begin
                        op_q <= new_op;
                        sec_q <= dec_second;
                        code2_q <= dec_code2;
                        if (new_op == `OP_POWER_DOWN)
                        begin
                            state_q <= SEQ_PD_LOW;
                            cnt_q <= `CNT_W'(`PD_LOW_CYC - 1);
                        end
                        else
                        begin
                            state_q <= dec_first ? SEQ_FIRST : SEQ_SECOND;
                            cyc_start_q <= 1'b1;
                            cyc_write_q <= dec_first;
                            cyc_wdata_q <= dec_code1;
                        end
                    end
                end
                SEQ_FIRST:
                begin
                    if (cyc_done && sec_q != SEC_NONE)
                    begin
                        state_q <= SEQ_SECOND;
                        cyc_start_q <= 1'b1;
                        cyc_write_q <= (sec_q == SEC_WRITE);
                        cyc_wdata_q <= code2_q;
                    end
                    else if (cyc_done)
                        state_q <= SEQ_IDLE;
                end
                SEQ_SECOND:
                begin
                    if (cyc_done)
                    begin
                        state_q <= SEQ_IDLE;
                        if (sec_q == SEC_READ)
                            rdata_q <= cyc_rdata;
                    end
                end
                SEQ_PD_LOW:
                begin
                    if (cnt_q == '0)
                    begin
                        state_q <= SEQ_PD_WAKE;
                        cnt_q <= `CNT_W'(`PD_WAKE_CYC - 1);
                    end
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                SEQ_PD_WAKE:
                begin
                    if (cnt_q == '0)
                        state_q <= SEQ_IDLE;
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                default: state_q <= SEQ_IDLE;
            endcase
        end
    end

    // Shadow of the device read mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= MODE_ARRAY;
            suspended_q <= 1'b0;
        end
        else if (clk_en && finish)
        begin
            unique case (op_q)
                `OP_READ_ARRAY: mode_q <= MODE_ARRAY;
                `OP_READ_ID: mode_q <= MODE_ID;
                `OP_READ_STATUS: mode_q <= MODE_STATUS;
                `OP_CLEAR_STATUS, `OP_READ: mode_q <= mode_q;
                `OP_POWER_DOWN:
                begin
                    mode_q <= MODE_ARRAY;
                    suspended_q <= 1'b0;
                end
                `OP_SUSPEND:
                begin
                    mode_q <= MODE_STATUS;
                    suspended_q <= 1'b1;
                end
                `OP_RESUME:
                begin
                    mode_q <= MODE_STATUS;
                    suspended_q <= 1'b0;
                end
                default: mode_q <= MODE_STATUS;
            endcase
        end
    end

    // Pins
    assign powerdown_reset_n = (state_q != SEQ_PD_LOW);
    assign high_voltage_level = vhh_q;

    // each read ends with strobes high
    flash_bus_cycle cycle_engine (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .start(cyc_start_q),
        .is_write(cyc_write_q),
        .addr(addr_q),
        .wdata(cyc_wdata_q),
        .dq_i(flash_dq_i),
        .ce_n(flash_ce_n),
        .oe_n(flash_oe_n),
        .we_n(flash_we_n),
        .addr_o(flash_addr),
        .dq_o(flash_dq_o),
        .dq_oe(flash_dq_oe),
        .rdata(cyc_rdata),
        .done(cyc_done)
    );

endmodule

// >>> rtl/flash_host_cfg.svh
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// Flash pin timing in 10 ns cycles
`define SETUP_CYC 2
`define STROBE_CYC 6
`define HOLD_CYC 2
`define PD_LOW_CYC 10
`define PD_WAKE_CYC 100
`define CNT_W 8

// Register byte offsets
`define CMD_OFS 12'h000
`define ADDR_OFS 12'h004
`define WDATA_OFS 12'h008
`define STATUS_OFS 12'h00c

`define CMD_OP_LSB 0
`define CMD_OP_MSB 3
`define CMD_VHH_BIT 4
`define CMD_ALT_BIT 5

`define ST_BUSY_BIT 0
`define ST_RYBY_BIT 1
`define ST_SUSP_BIT 2
`define ST_REFUSED_BIT 3
`define ST_MODE_LSB 4
`define ST_MODE_MSB 5
`define ST_SRDY_BIT 6
`define ST_RDATA_LSB 8
`define ST_RDATA_MSB 15

// Operation codes
`define OP_READ_ARRAY 4'h0
`define OP_READ_ID 4'h1
`define OP_READ_STATUS 4'h2
`define OP_CLEAR_STATUS 4'h3
`define OP_ERASE 4'h4
`define OP_PROGRAM 4'h5
`define OP_SUSPEND 4'h6
`define OP_RESUME 4'h7
`define OP_LOCK_BLOCK 4'h8
`define OP_LOCK_MASTER 4'h9
`define OP_UNLOCK_ALL 4'ha
`define OP_READ 4'hb
`define OP_POWER_DOWN 4'hc

// Flash command codes
`define FC_READ_ARRAY 8'hff
`define FC_READ_ID 8'h90
`define FC_READ_STATUS 8'h70
`define FC_CLEAR_STATUS 8'h50
`define FC_ERASE_SETUP 8'h20
`define FC_CONFIRM 8'hd0
`define FC_PROGRAM 8'h40
`define FC_PROGRAM_ALT 8'h10
`define FC_SUSPEND 8'hb0
`define FC_LOCK_SETUP 8'h60
`define FC_LOCK_BLOCK 8'h01
`define FC_LOCK_MASTER 8'hf1

// Status ready bit
`define SR_READY_BIT 7

// Reset values
`define CMD_RST 6'h00
`define ADDR_RST 21'h00_0000
`define BYTE_RST 8'h00

`endif

// >>> rtl/flash_host_pkg.sv
package flash_host_pkg;

    typedef enum logic [2:0] {SEQ_IDLE, SEQ_FIRST, SEQ_SECOND, SEQ_PD_LOW, SEQ_PD_WAKE} seq_state_t;

    typedef enum logic [1:0] {CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD} cyc_state_t;

    typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_STATUS} read_mode_t;

    typedef enum logic [1:0] {SEC_NONE, SEC_WRITE, SEC_READ} second_kind_t;

endpackage

// >>> rtl/flash_bus_cycle.sv
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_bus_cycle
    import flash_host_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic start,
    input wire logic is_write,
    input wire logic [20:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] dq_i,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [20:0] addr_o,
    output logic [7:0] dq_o,
    output logic dq_oe,
    output logic [7:0] rdata,
    output logic done
);

    cyc_state_t state_q;
    logic [`CNT_W-1:0] cnt_q;
    logic write_q;
    wire cnt_zero = (cnt_q == '0);

    // One write or read cycle: setup, strobe low, strobe high with hold
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= CYC_IDLE;
            cnt_q <= '0;
            write_q <= 1'b0;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            addr_o <= `ADDR_RST;
            dq_o <= `BYTE_RST;
            dq_oe <= 1'b0;
            rdata <= `BYTE_RST;
            done <= 1'b0;
        end
        else if (clk_en)
        begin
            done <= 1'b0;
            unique case (state_q)
                CYC_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= CYC_SETUP;
                        cnt_q <= `CNT_W'(`SETUP_CYC - 1);
                        write_q <= is_write;
                        addr_o <= addr;
                        dq_o <= wdata;
                        dq_oe <= is_write;
                        ce_n <= 1'b0;
                    end
                end
                CYC_SETUP:
                begin
                    if (cnt_zero)
                    begin
                        state_q <= CYC_STROBE;
                        cnt_q <= `CNT_W'(`STROBE_CYC - 1);
                        we_n <= !write_q;
                        oe_n <= write_q;
                    end
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                CYC_STROBE:
                begin
                    if (cnt_zero)
                    begin
                        state_q <= CYC_HOLD;
                        cnt_q <= `CNT_W'(`HOLD_CYC - 1);
                        we_n <= 1'b1;
                        oe_n <= 1'b1;
                        if (!write_q)
                            rdata <= dq_i;
                    end
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
                CYC_HOLD:
                begin
                    if (cnt_zero)
                    begin
                        state_q <= CYC_IDLE;
                        ce_n <= 1'b1;
                        dq_oe <= 1'b0;
                        done <= 1'b1;
                    end
                    else
                        cnt_q <= cnt_q - 1'b1;
                end
            endcase
        end
    end

endmodule

// >>> testbench/flash_host_props.sv
`timescale 1ns/1ps
module flash_host_props (
    input logic pclk,
    input logic presetn,
    input logic clk_en,
    input logic [11:0] paddr,
    input logic psel,
    input logic penable,
    input logic pready,
    input logic pslverr,
    input logic [20:0] flash_addr,
    input logic [7:0] flash_dq_o,
    input logic flash_dq_oe,
    input logic flash_ce_n,
    input logic flash_oe_n,
    input logic flash_we_n,
    input logic powerdown_reset_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic we_q;
    logic pend_q;
    wire we_up = flash_we_n && !we_q;
    wire opener = flash_dq_o inside {8'h20, 8'h40, 8'h10, 8'h60};
    // Tracks whether the last write opened a two-cycle sequence
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            we_q <= 1'b1;
            pend_q <= 1'b0;
        end
        else
        begin
            we_q <= flash_we_n;
            if (we_up)
                pend_q <= !pend_q && opener;
        end
    a_strobe_excl: assert property (flash_oe_n || flash_we_n)
        else $error("strobes overlap");
    a_read_float: assert property (!flash_oe_n |-> !flash_dq_oe)
        else $error("data driven in read");
    a_write_held: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe
        ##1 $stable(flash_addr) && $stable(flash_dq_o)) else $error("write moved");
    a_read_width: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*6] ##1 flash_oe_n)
        else $error("read strobe width");
    a_write_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*6] ##1 flash_we_n)
        else $error("write strobe width");
    a_erase_pair: assert property (we_up && !pend_q && flash_dq_o == 8'h20 |->
        ##[1:40] !flash_we_n && flash_dq_o == 8'hd0) else $error("erase unconfirmed");
    a_lock_pair: assert property (we_up && !pend_q && flash_dq_o == 8'h60 |->
        ##[1:40] !flash_we_n && flash_dq_o inside {8'h01, 8'hf1, 8'hd0})
        else $error("lock code missing");
    a_prog_pair: assert property (we_up && !pend_q && flash_dq_o inside {8'h40, 8'h10} |->
        ##[1:40] !flash_we_n) else $error("program data missing");
    a_pd_pulse: assert property ($fell(powerdown_reset_n) |-> !powerdown_reset_n [*8])
        else $error("power-down pulse short");
    a_wake_quiet: assert property ($rose(powerdown_reset_n) |-> flash_ce_n [*8])
        else $error("access in wake-up");
    a_apb_answer: assert property (psel && penable |-> pready == clk_en
        && pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c}))
        else $error("bad apb answer");
    c_erase: cover property (we_up && pend_q && flash_dq_o == 8'hd0);
    c_read: cover property ($rose(flash_oe_n));
    c_wake: cover property ($rose(powerdown_reset_n));
endmodule
bind flash_host_controller flash_host_props props_u (.pclk, .presetn, .clk_en, .paddr,
    .psel, .penable, .pready, .pslverr, .flash_addr, .flash_dq_o, .flash_dq_oe,
    .flash_ce_n, .flash_oe_n, .flash_we_n, .powerdown_reset_n);

// >>> testbench/flash_model.sv
`timescale 1ns/1ps
module flash_model #(
    // Identity codes are arbitrary
    parameter logic [7:0] MAKER_CODE = 8'h3c,
    parameter logic [7:0] PART_CODE = 8'h5a,
    parameter int BUSY_CYC = 80
) (
    input logic pclk,
    input logic [20:0] addr,
    input logic [7:0] dq_in,
    output logic [7:0] dq_out,
    input logic ce_n,
    input logic oe_n,
    input logic we_n,
    input logic rp_n,
    input logic hv,
    output logic ready_busy_n
);
    logic [7:0] mem [8192];
    logic [31:0] lock_q = '0;
    logic master_q = 1'b0, susp_q = 1'b0, wr_q = 1'b0, rd_q = 1'b0;
    logic [1:0] mode_q = 2'h0;
    logic [7:0] pend_q = 8'h00, err_q = 8'h00, srd_q = 8'h80, last_q = 8'h00;
    int busy_q = 0;
    wire wr = !we_n && !ce_n;
    wire rd = !oe_n && !ce_n;
    wire [4:0] blk = addr[20:16];
    wire ok = !lock_q[blk] || hv;
    wire [7:0] id_val = addr[1:0] == 2'h0 ? MAKER_CODE : addr[1:0] == 2'h1 ? PART_CODE
        : {7'h00, addr[0] ? master_q : lock_q[blk]};
    initial
        foreach (mem[k])
            mem[k] = 8'hff;
    // busy while an operation runs unsuspended
    assign ready_busy_n = busy_q == 0 || susp_q || !rp_n;
    // read data by mode, inverse of last value when released
    assign dq_out = !rd ? ~last_q : mode_q == 2'h2 ? srd_q : mode_q == 2'h1 ? id_val
        : mem[{blk, addr[7:0]}];
    always @(posedge pclk)
    begin
        wr_q <= wr;
        rd_q <= rd;
        if (rd)
            last_q <= dq_out;
        // status captured as the read strobe falls
        if (rd && !rd_q)
            srd_q <= {ready_busy_n, susp_q, err_q[5:0]};
        if (busy_q > 0 && !susp_q)
            busy_q <= busy_q - 1;
        if (!rp_n)
        begin
            mode_q <= 2'h0;
            err_q <= 8'h00;
            busy_q <= 0;
            susp_q <= 1'b0;
            pend_q <= 8'h00;
        end
        // command or second byte taken as each write strobe rises
        else if (wr_q && !wr)
        begin
            pend_q <= 8'h00;
            if (pend_q != 8'h00)
                mode_q <= 2'h2;
            if (pend_q != 8'h00 && (pend_q != 8'h20 || dq_in == 8'hd0))
                busy_q <= BUSY_CYC;
            // erase needs confirm and open block
            if (pend_q == 8'h20)
            begin
                if (dq_in != 8'hd0)
                    err_q <= err_q | 8'h30;
                else if (!ok)
                    err_q <= err_q | 8'h22;
                else
                    for (int k = 0; k < 256; k++)
                        mem[{blk, k[7:0]}] = 8'hff;
            end
            // program data, refused on a locked block
            else if (pend_q == 8'h40 || pend_q == 8'h10)
            begin
                if (ok)
                    mem[{blk, addr[7:0]}] = dq_in;
                else
                    err_q <= err_q | 8'h12;
            end
            // lock bits gated by master and high voltage
            else if (pend_q == 8'h60)
            begin
                if (dq_in == 8'h01 && (!master_q || hv))
                    lock_q[blk] <= 1'b1;
                else if (dq_in == 8'hf1 && hv)
                    master_q <= 1'b1;
                else if (dq_in == 8'hd0 && (!master_q || hv))
                    lock_q <= '0;
                else
                    err_q <= err_q | 8'h02;
            end
            // only suspend and status while running
            else if (busy_q != 0 && !susp_q)
            begin
                if (dq_in == 8'hb0)
                    susp_q <= 1'b1;
                else if (dq_in == 8'h70)
                    mode_q <= 2'h2;
            end
            else
                case (dq_in)
                    8'hff: mode_q <= 2'h0;
                    8'h90: mode_q <= 2'h1;
                    8'h70: mode_q <= 2'h2;
                    8'h50: if (!susp_q) err_q <= 8'h00;
                    8'hd0: susp_q <= 1'b0;
                    8'h20, 8'h40, 8'h10, 8'h60: pend_q <= dq_in;
                    default: ;
                endcase
        end
    end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module tb;
    localparam logic [7:0] MAKER = 8'h3c;
    localparam logic [7:0] PART = 8'h5a;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q, st;
    logic pready, pslverr, err, dq_oe, ce_n, oe_n, we_n, rp_n, hv, rb_n;
    logic [20:0] fa, a;
    logic [7:0] dqo, fo, rnd = 8'h48;
    wire logic [7:0] dq = dq_oe ? dqo : fo;
    int num_errors = 0, check_count = 0, cycles = 0;
    logic [7:0] exp_mem [int];
    always #5 pclk = ~pclk;
    flash_host_controller dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(fa),
        .flash_dq_i(dq), .flash_dq_o(dqo), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .powerdown_reset_n(rp_n),
        .high_voltage_level(hv), .ready_busy_n(rb_n));
    flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) mdl_u (.pclk, .addr(fa),
        .dq_in(dq), .dq_out(fo), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n),
        .hv(hv), .ready_busy_n(rb_n));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] d = 0);
        psel <= 1'b1;
        paddr <= ad;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic op(input logic [3:0] c, input logic [20:0] ad = 0, input logic [7:0] d = 0,
        input logic [1:0] f = 0);
        apb(`ADDR_OFS, 1'b1, 32'(ad));
        apb(`WDATA_OFS, 1'b1, 32'(d));
        apb(`CMD_OFS, 1'b1, 32'({f, c}));
        do
            apb(`STATUS_OFS, 1'b0);
        while (q[0] !== 1'b0);
        st = q;
    endtask
    task automatic idle;
        do
            apb(`STATUS_OFS, 1'b0);
        while (q[1] !== 1'b1);
    endtask
    task automatic rb(input logic [3:0] c, input logic [20:0] ad, input logic [7:0] e);
        op(c, ad);
        chk("read byte", 32'(st[15:8]), 32'(e));
    endtask
    task automatic arr;
        op(4'h0);
        chk("array mode", 32'(st[5:4]), 32'h0);
        foreach (exp_mem[k])
            rb(4'hb, 21'(k), exp_mem[k]);
        $display("array pass done");
    endtask
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            num_errors++;
            close_out;
        end
    end
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(`STATUS_OFS, 1'b0);
        chk("reset status", q & 32'h0000_ffff, 32'h0000_0002);
        apb(12'h010, 1'b0);
        chk("unmapped", q | 32'(!err), 32'h0);
        clk_en <= 1'b0;
        @(posedge pclk);
        chk("frozen pready", 32'(pready), 32'h0);
        clk_en <= 1'b1;
        $display("bus test done");
        for (int i = 0; i < 4; i++)
            rb(4'h1, 21'(i), i == 0 ? MAKER : i == 1 ? PART : 8'h00);
        chk("id mode", 32'(st[5:4]), 32'h1);
        rb(4'h2, 21'h0, 8'h80);
        chk("ready bit", 32'(st[6]), 32'h1);
        $display("read mode test done");
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            a = {5'(i + 1), 8'h00, rnd};
            rnd = lfsr(rnd);
            exp_mem[int'(a)] = rnd;
            op(4'h5, a, rnd, {i[0], 1'b0});
            idle;
        end
        arr;
        op(4'h4, 21'h01_0000);
        chk("busy in erase", 32'(st[1]), 32'h0);
        op(4'h0);
        chk("array refused", 32'(st[3]), 32'h1);
        apb(`STATUS_OFS, 1'b1, 32'h8);
        op(4'h6);
        chk("suspended", 32'(st[3:1]), 32'h3);
        op(4'h3);
        chk("clear refused", 32'(st[3]), 32'h1);
        apb(`STATUS_OFS, 1'b1, 32'h8);
        op(4'h7);
        chk("resumed", 32'(st[2:1]), 32'h0);
        idle;
        foreach (exp_mem[k])
            if (k[20:16] == 1)
                exp_mem[k] = 8'hff;
        arr;
        op(4'h8, 21'h02_0000);
        idle;
        rb(4'h1, 21'h02_0002, 8'h01);
        op(4'h5, 21'h02_0005);
        idle;
        rb(4'h2, 21'h0, 8'h92);
        op(4'h3);
        rb(4'h2, 21'h0, 8'h80);
        op(4'h9, 0, 0, 2'h1);
        idle;
        rb(4'h1, 21'h00_0003, 8'h01);
        op(4'h8, 21'h03_0000);
        idle;
        rb(4'h1, 21'h03_0002, 8'h00);
        op(4'ha, 0, 0, 2'h1);
        idle;
        rb(4'h1, 21'h02_0002, 8'h00);
        $display("lock test done");
        op(4'hd);
        chk("undefined op", 32'(st[5:3]), 32'h3);
        op(4'h8, 21'h03_0000);
        idle;
        op(4'hc);
        chk("wake mode", 32'(st[5:4]), 32'h0);
        rb(4'h2, 21'h0, 8'h80);
        $display("power-down test done");
        close_out;
    end
endmodule
